// *** hdl/sdrb_pkg.sv ***
package sdrb_pkg;

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 13;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned MASK_W      = DATA_W / 8;  // one byte mask per eight data lines
  localparam int unsigned BANK_W      = 1;
  localparam int unsigned BANKS       = 2;
  localparam int unsigned COL_W       = 3;
  localparam int unsigned MEM_AW      = BANK_W + COL_W;
  localparam int unsigned MEM_WORDS   = 16;
  localparam int unsigned LINE_AW     = 5;
  localparam int unsigned LINE_DEPTH  = 32;          // holds the longest read or write latency
  localparam int unsigned CNT_W       = 6;
  localparam int unsigned FAULT_W     = 3;
  localparam int          BURST_SEL_BIT = 12;        // burst_select_address_bit position

  // ----------------------------------------------------------------
  // mode field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] BF_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BF_ON_FLY      = 2'h1;
  localparam logic [1:0] BF_FIXED_CHOP  = 2'h2;
  localparam logic [1:0] ADD_ZERO       = 2'h0;
  localparam logic [1:0] ADD_CAS_M1     = 2'h1;
  localparam logic [1:0] ADD_CAS_M2     = 2'h2;

  // ----------------------------------------------------------------
  // burst timing in link clock cycles
  // ----------------------------------------------------------------
  localparam logic [1:0] BURST_LAST_BEAT = 2'h3;     // four cycles per column command
  localparam logic [1:0] CHOP_LAST_BEAT  = 2'h1;     // chop carries data in the first two cycles

  // ----------------------------------------------------------------
  // array timing checks
  // ----------------------------------------------------------------
  localparam int unsigned LINK_PERIOD_PS = 15000;
  localparam int unsigned RTP_MIN_CK     = 4;
  localparam int unsigned RTP_MIN_PS     = 7500;
  localparam int unsigned RTP_PS_CYC     = (RTP_MIN_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam logic [CNT_W-1:0] RTP_CYC   = CNT_W'((RTP_PS_CYC > RTP_MIN_CK) ? RTP_PS_CYC : RTP_MIN_CK);
  localparam logic [CNT_W-1:0] RAS_CYC   = 6'h0f;
  localparam logic [CNT_W-1:0] RP_CYC    = 6'h05;
  localparam logic [CNT_W-1:0] RC_CYC    = 6'h14;
  localparam logic [CNT_W-1:0] CNT_SAT   = 6'h3f;
  localparam int FLT_RTP = 0;
  localparam int FLT_RAS = 1;
  localparam int FLT_ACT = 2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE} sdrb_op_e;

  typedef struct packed {
    sdrb_op_e            op;
    logic [BANK_W-1:0]   bank;
    logic [ADDR_W-1:0]   addr;
  } sdrb_cmd_s;

  typedef struct packed {
    logic [DATA_W-1:0]   rise;
    logic [DATA_W-1:0]   fall;
    logic [MASK_W-1:0]   mask_rise;
    logic [MASK_W-1:0]   mask_fall;
  } sdrb_wdata_s;

  typedef struct packed {
    logic                valid;
    logic [DATA_W-1:0]   rise;
    logic [DATA_W-1:0]   fall;
  } sdrb_rdata_s;

  typedef struct packed {
    logic [1:0]          burst_field;
    logic [3:0]          cas_lat;
    logic [3:0]          cas_wr_lat;
    logic [1:0]          add_mode;
    logic                term_en;
  } sdrb_cfg_s;

  typedef struct packed {
    logic                valid;
    logic                wr;
    logic                chop;
    logic [BANK_W-1:0]   bank;
    logic [COL_W-1:0]    col;
  } sdrb_rec_s;

  typedef struct packed {
    logic                active;
    logic                chop;
    logic [BANK_W-1:0]   bank;
    logic [COL_W-1:0]    col;
    logic [1:0]          beat;
  } sdrb_eng_s;

endpackage

// *** hdl/sdrb_sync.sv ***
// two-flop level synchroniser; the first stage feeds only the second
module sdrb_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic [WIDTH-1:0] async_in,  // level from another domain
  input  wire logic             clk_in,    // destination clock
  input  wire logic             reset_in,  // destination sync reset, high
  output logic      [WIDTH-1:0] sync_out   // synchronised level
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sdrb_sync_s;

  sdrb_sync_s st;
  sdrb_sync_s next_st;

  // shift the level through both stages
  always_comb begin
    next_st.first  = async_in;
    next_st.second = st.first;
    if (reset_in) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    st <= next_st;
  end

  assign sync_out = st.second;

endmodule

// *** hdl/sdrb_core.sv ***
// Function
// - with burst field 01, burst_select_address_bit low gives chopped four beats, high gives eight beats.
// - burst_select_address_bit is never part of the column address.
// - eight beats when burst field is 00, or 01 with select bit high.
// - data setup or hold faults may spoil only the addressed write location.
// - strobe shape or skew faults may spoil only the addressed write location.
// - one write_byte_mask per eight data lines, sampled like the data.
// - write_byte_mask is input only and timed exactly as data.
// - write_byte_mask is ignored during reads.
// - with termination enabled, mask pin acts as termination_data_strobe during writes.
// - read_latency equals additive_latency plus cas_read_latency.
// - write_latency equals additive_latency plus cas_write_latency.
// - burst field 10 forces chopped four beats whatever the select bit.
module sdrb_core (
  input  wire logic                  sys_clk_in,      // register side clock
  input  wire logic                  reset_in,        // sync reset, high
  input  wire logic                  link_clk_in,     // command clock from controller
  input  wire sdrb_pkg::sdrb_cfg_s   cfg_in,          // mode settings, sys domain
  input  wire sdrb_pkg::sdrb_cmd_s   cmd_in,          // command, link domain
  input  wire sdrb_pkg::sdrb_wdata_s wdata_in,        // write beats and masks, link domain
  output sdrb_pkg::sdrb_rdata_s      rdata_out,       // read beats, link domain
  output logic                       term_strobe_out, // termination strobe, link domain
  output logic [sdrb_pkg::FAULT_W-1:0] fault_out,     // sticky spacing faults, sys domain
  output logic [sdrb_pkg::BANKS-1:0] bank_open_out    // open row per bank, sys domain
);

  // ----------------------------------------------------------------
  // link-domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    sdrb_pkg::sdrb_rec_s [sdrb_pkg::LINE_DEPTH-1:0]                line;
    sdrb_pkg::sdrb_eng_s                                           rd;
    sdrb_pkg::sdrb_eng_s                                           wr;
    logic [sdrb_pkg::MEM_WORDS-1:0][sdrb_pkg::DATA_W-1:0]          mem;
    logic [sdrb_pkg::BANKS-1:0]                                    open;
    logic [sdrb_pkg::BANKS-1:0][sdrb_pkg::CNT_W-1:0]               since_rd;
    logic [sdrb_pkg::BANKS-1:0][sdrb_pkg::CNT_W-1:0]               since_act;
    logic [sdrb_pkg::BANKS-1:0][sdrb_pkg::CNT_W-1:0]               since_pre;
    logic [sdrb_pkg::FAULT_W-1:0]                                  fault;
    sdrb_pkg::sdrb_rdata_s                                         rdata;
    logic                                                          term;
  } sdrb_link_s;

  sdrb_link_s                                   st;
  sdrb_link_s                                   next_st;
  logic                                         rst_link;
  sdrb_pkg::sdrb_cfg_s                          cfg_link;
  logic [sdrb_pkg::LINE_AW-1:0]                 cl5;
  logic [sdrb_pkg::LINE_AW-1:0]                 cwl5;
  logic [sdrb_pkg::LINE_AW-1:0]                 lat_add;
  logic [sdrb_pkg::LINE_AW-1:0]                 lat_rd;
  logic [sdrb_pkg::LINE_AW-1:0]                 lat_wr;
  logic [sdrb_pkg::LINE_AW-1:0]                 rd_tap;
  logic [sdrb_pkg::LINE_AW-1:0]                 wr_tap;
  logic                                         cmd_chop;
  logic [sdrb_pkg::FAULT_W+sdrb_pkg::BANKS-1:0] status_sys;

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  // reset reaches the link domain as a level; link clock must run while it is held
  sdrb_sync #(.WIDTH(1)) u_rst_sync (
    .async_in (reset_in),
    .clk_in   (link_clk_in),
    .reset_in (1'b0),
    .sync_out (rst_link)
  );

  // mode settings are quasi-static: change them only with no burst in flight
  sdrb_sync #(.WIDTH($bits(sdrb_pkg::sdrb_cfg_s))) u_cfg_sync (
    .async_in (cfg_in),
    .clk_in   (link_clk_in),
    .reset_in (rst_link),
    .sync_out (cfg_link)
  );

  // status levels back to the sys domain; bits settle independently
  sdrb_sync #(.WIDTH(sdrb_pkg::FAULT_W + sdrb_pkg::BANKS)) u_sts_sync (
    .async_in ({st.fault, st.open}),
    .clk_in   (sys_clk_in),
    .reset_in (reset_in),
    .sync_out (status_sys)
  );

  assign fault_out     = status_sys[sdrb_pkg::FAULT_W+sdrb_pkg::BANKS-1:sdrb_pkg::BANKS];
  assign bank_open_out = status_sys[sdrb_pkg::BANKS-1:0];

  // ----------------------------------------------------------------
  // latencies and burst length
  // ----------------------------------------------------------------
  // additive latency is zero, the cas latency minus one, or the cas latency minus two
  assign cl5  = {1'b0, cfg_link.cas_lat};
  assign cwl5 = {1'b0, cfg_link.cas_wr_lat};
  assign lat_add = (cfg_link.add_mode == sdrb_pkg::ADD_CAS_M1) ? 5'(cl5 - 5'h01) :
                   (cfg_link.add_mode == sdrb_pkg::ADD_CAS_M2) ? 5'(cl5 - 5'h02) : 5'h00;
  assign lat_rd  = 5'(lat_add + cl5);
  assign lat_wr  = 5'(lat_add + cwl5);
  // the line entry that has aged exactly one cycle short of the latency starts the burst
  assign rd_tap = (lat_rd == 5'h00) ? 5'h00 : 5'(lat_rd - 5'h01);
  assign wr_tap = (lat_wr == 5'h00) ? 5'h00 : 5'(lat_wr - 5'h01);

  // burst length per command
  always_comb begin
    case (cfg_link.burst_field)
      sdrb_pkg::BF_FIXED_EIGHT: cmd_chop = 1'b0;
      sdrb_pkg::BF_ON_FLY:      cmd_chop = ~cmd_in.addr[sdrb_pkg::BURST_SEL_BIT];
      sdrb_pkg::BF_FIXED_CHOP:  cmd_chop = 1'b1;
      default:                  cmd_chop = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // word address of one beat; a chop wraps within its aligned four columns
  function automatic logic [sdrb_pkg::MEM_AW-1:0] beat_addr(input sdrb_pkg::sdrb_eng_s e, input logic half);
    logic [2:0]                  beat_no;
    logic [sdrb_pkg::COL_W-1:0]  col;
    beat_no = {e.beat, half};
    if (e.chop) begin
      col = {e.col[2], 2'(e.col[1:0] + beat_no[1:0])};
    end else begin
      col = 3'(e.col + beat_no);
    end
    return {e.bank, col};
  endfunction

  // one step of a burst engine; a new start overrides the running burst at any beat
  function automatic sdrb_pkg::sdrb_eng_s eng_step(input sdrb_pkg::sdrb_eng_s cur,
                                                   input sdrb_pkg::sdrb_rec_s tap,
                                                   input logic want_wr);
    sdrb_pkg::sdrb_eng_s nxt;
    nxt = cur;
    if (tap.valid && (tap.wr == want_wr)) begin
      nxt.active = 1'b1;
      nxt.chop   = tap.chop;
      nxt.bank   = tap.bank;
      nxt.col    = tap.col;
      nxt.beat   = 2'h0;
    end else if (cur.active && (cur.beat != sdrb_pkg::BURST_LAST_BEAT)) begin
      nxt.beat = 2'(cur.beat + 2'h1);
    end else begin
      nxt.active = 1'b0;
    end
    return nxt;
  endfunction

  // chopped bursts hold the slot four cycles but carry data in only two
  function automatic logic has_data(input sdrb_pkg::sdrb_eng_s e);
    return e.active && (!e.chop || (e.beat <= sdrb_pkg::CHOP_LAST_BEAT));
  endfunction

  // ----------------------------------------------------------------
  // link-domain next state
  // ----------------------------------------------------------------
  always_comb begin
    sdrb_pkg::sdrb_eng_s      rd_n;
    sdrb_pkg::sdrb_eng_s      wr_n;
    logic [sdrb_pkg::CNT_W:0] rtp_need;
    rd_n     = '0;
    wr_n     = '0;
    rtp_need = '0;
    next_st  = st;

    // latency line: every column command is queued with its own burst length
    next_st.line[0].valid = (cmd_in.op == sdrb_pkg::OP_RD) || (cmd_in.op == sdrb_pkg::OP_WR);
    next_st.line[0].wr    = (cmd_in.op == sdrb_pkg::OP_WR);
    next_st.line[0].chop  = cmd_chop;
    next_st.line[0].bank  = cmd_in.bank;
    next_st.line[0].col   = cmd_in.addr[sdrb_pkg::COL_W-1:0];
    for (int i = 1; i < sdrb_pkg::LINE_DEPTH; i++) begin
      next_st.line[i] = st.line[i-1];
    end

    // read burst: data leaves read_latency cycles after the command
    rd_n               = eng_step(st.rd, st.line[rd_tap], 1'b0);
    next_st.rd         = rd_n;
    next_st.rdata.valid = has_data(rd_n);
    next_st.rdata.rise = st.mem[beat_addr(rd_n, 1'b0)];
    next_st.rdata.fall = st.mem[beat_addr(rd_n, 1'b1)];

    // write burst: beats are taken on the latency count, never on strobe shape, so a
    // strobe fault can spoil only the addressed words and cannot stall later commands
    wr_n       = eng_step(st.wr, st.line[wr_tap], 1'b1);
    next_st.wr = wr_n;
    if (has_data(wr_n)) begin
      if (cfg_link.term_en || !wdata_in.mask_rise[0]) begin
        next_st.mem[beat_addr(wr_n, 1'b0)] = wdata_in.rise;
      end
      if (cfg_link.term_en || !wdata_in.mask_fall[0]) begin
        next_st.mem[beat_addr(wr_n, 1'b1)] = wdata_in.fall;
      end
    end
    // mask pin turns into the termination strobe for the whole write slot
    next_st.term = cfg_link.term_en && wr_n.active;

    // per-bank spacing watch; a short gap is only recorded, the array keeps working
    rtp_need = 7'(lat_add) + 7'(sdrb_pkg::RTP_CYC);
    for (int b = 0; b < sdrb_pkg::BANKS; b++) begin
      if (st.since_rd[b]  != sdrb_pkg::CNT_SAT) next_st.since_rd[b]  = 6'(st.since_rd[b]  + 6'h01);
      if (st.since_act[b] != sdrb_pkg::CNT_SAT) next_st.since_act[b] = 6'(st.since_act[b] + 6'h01);
      if (st.since_pre[b] != sdrb_pkg::CNT_SAT) next_st.since_pre[b] = 6'(st.since_pre[b] + 6'h01);
      if (cmd_in.bank == 1'(b)) begin
        case (cmd_in.op)
          sdrb_pkg::OP_ACT: begin
            if (st.open[b] ||
                (7'(st.since_pre[b]) + 7'h01 < 7'(sdrb_pkg::RP_CYC)) ||
                (7'(st.since_act[b]) + 7'h01 < 7'(sdrb_pkg::RC_CYC))) begin
              next_st.fault[sdrb_pkg::FLT_ACT] = 1'b1;
            end
            next_st.open[b]      = 1'b1;
            next_st.since_act[b] = '0;
          end
          sdrb_pkg::OP_RD: begin
            next_st.since_rd[b] = '0;
          end
          sdrb_pkg::OP_PRE: begin
            if (7'(st.since_rd[b]) + 7'h01 < rtp_need) begin
              next_st.fault[sdrb_pkg::FLT_RTP] = 1'b1;
            end
            if (st.open[b] && (7'(st.since_act[b]) + 7'h01 < 7'(sdrb_pkg::RAS_CYC))) begin
              next_st.fault[sdrb_pkg::FLT_RAS] = 1'b1;
            end
            // a precharge to an idle bank still restarts the precharge period
            next_st.open[b]      = 1'b0;
            next_st.since_pre[b] = '0;
          end
          default: begin
          end
        endcase
      end
    end

    if (rst_link) begin
      next_st = '0;
      for (int b = 0; b < sdrb_pkg::BANKS; b++) begin
        next_st.since_rd[b]  = sdrb_pkg::CNT_SAT;
        next_st.since_act[b] = sdrb_pkg::CNT_SAT;
        next_st.since_pre[b] = sdrb_pkg::CNT_SAT;
      end
    end
  end

  // ----------------------------------------------------------------
  // link-domain registers
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_in) begin
    st <= next_st;
  end

  assign rdata_out       = st.rdata;
  assign term_strobe_out = st.term;

endmodule

// *** tb/sdrb_core_monitor.sv ***
module sdrb_core_monitor (
  input wire logic                         sys_clk_in,      // sys clock
  input wire logic                         reset_in,        // sync reset, high
  input wire logic                         link_clk_in,     // command clock
  input wire sdrb_pkg::sdrb_cfg_s          cfg_in,          // mode settings
  input wire sdrb_pkg::sdrb_cmd_s          cmd_in,          // command
  input wire sdrb_pkg::sdrb_wdata_s        wdata_in,        // write beats
  input wire sdrb_pkg::sdrb_rdata_s        rdata_out,       // read beats
  input wire logic                         term_strobe_out, // termination strobe
  input wire logic [sdrb_pkg::FAULT_W-1:0] fault_out,       // spacing faults
  input wire logic [sdrb_pkg::BANKS-1:0]   bank_open_out    // open rows
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // command history, one bit per link cycle
  // ----------------------------------------------------------------
  logic [39:0] rd_hist, rd8_hist, wr_hist;
  logic [5:0]  lat_add, lat_rd, lat_wr;
  logic        chop, exp_valid, exp_term;

  // latencies follow the live mode; the mode only changes while idle
  always_comb begin
    lat_add = (cfg_in.add_mode == sdrb_pkg::ADD_CAS_M1) ? 6'(cfg_in.cas_lat) - 6'h01 :
              (cfg_in.add_mode == sdrb_pkg::ADD_CAS_M2) ? 6'(cfg_in.cas_lat) - 6'h02 : 6'h00;
    lat_rd = lat_add + 6'(cfg_in.cas_lat);
    lat_wr = lat_add + 6'(cfg_in.cas_wr_lat);
    chop = (cfg_in.burst_field == sdrb_pkg::BF_FIXED_CHOP) ||
           (cfg_in.burst_field == sdrb_pkg::BF_ON_FLY && !cmd_in.addr[sdrb_pkg::BURST_SEL_BIT]);
    exp_valid = rd_hist[lat_rd] | rd_hist[lat_rd+6'h01] | rd8_hist[lat_rd+6'h02] | rd8_hist[lat_rd+6'h03];
    exp_term = cfg_in.term_en &
               (wr_hist[lat_wr] | wr_hist[lat_wr+6'h01] | wr_hist[lat_wr+6'h02] | wr_hist[lat_wr+6'h03]);
  end

  // cleared in reset so stale commands never raise expectations
  always_ff @(posedge link_clk_in) begin
    if (reset_in) begin
      rd_hist <= '0;
      rd8_hist <= '0;
      wr_hist <= '0;
    end else begin
      rd_hist <= {rd_hist[38:0], cmd_in.op == sdrb_pkg::OP_RD};
      rd8_hist <= {rd8_hist[38:0], cmd_in.op == sdrb_pkg::OP_RD && !chop};
      wr_hist <= {wr_hist[38:0], cmd_in.op == sdrb_pkg::OP_WR};
    end
  end

  AST_READ_START: assert property (@(posedge link_clk_in) disable iff (reset_in)
    rd_hist[lat_rd] |-> rdata_out.valid) else $error("read data late or missing");
  AST_EIGHT_SPAN: assert property (@(posedge link_clk_in) disable iff (reset_in)
    (rd8_hist[lat_rd+6'h02] | rd8_hist[lat_rd+6'h03]) |-> rdata_out.valid) else $error("eight-beat read cut short");
  AST_NO_EXTRA_DATA: assert property (@(posedge link_clk_in) disable iff (reset_in)
    !exp_valid |-> !rdata_out.valid) else $error("read data outside burst");
  AST_MIN_DATA_CYCLES: assert property (@(posedge link_clk_in) disable iff (reset_in)
    $rose(rdata_out.valid) |-> rdata_out.valid [*2]) else $error("read burst under two cycles");
  AST_TERM_WINDOW: assert property (@(posedge link_clk_in) disable iff (reset_in)
    exp_term |-> term_strobe_out) else $error("termination strobe missing in write slot");
  AST_TERM_ONLY_WRITE: assert property (@(posedge link_clk_in) disable iff (reset_in)
    term_strobe_out |-> exp_term) else $error("termination strobe outside write slot");
  AST_TERM_FOUR: assert property (@(posedge link_clk_in) disable iff (reset_in)
    $rose(term_strobe_out) |=> term_strobe_out [*3]) else $error("termination strobe under four cycles");
  AST_FAULT_STICKY: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (fault_out & $past(fault_out)) == $past(fault_out)) else $error("fault bit cleared without reset");
endmodule

bind sdrb_core sdrb_core_monitor i_mon (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .link_clk_in(link_clk_in), .cfg_in(cfg_in),
  .cmd_in(cmd_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .term_strobe_out(term_strobe_out),
  .fault_out(fault_out), .bank_open_out(bank_open_out)
);

// *** tb/sdrb_ctrl_model.sv ***
module sdrb_ctrl_model (
  input  wire logic           link_clk_in, // command clock
  output sdrb_pkg::sdrb_cmd_s   cmd_out,     // command and address
  output sdrb_pkg::sdrb_wdata_s wdata_out    // write beats and masks
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    cmd_out = '{sdrb_pkg::OP_NOP, 1'b0, 13'h0000};
    wdata_out = '0;
  end

  // one command per cycle; spacing comes from the caller's gap
  task automatic issue(input sdrb_pkg::sdrb_op_e op, input logic b, input logic [12:0] a, input int gap);
    @(negedge link_clk_in);
    cmd_out <= '{op, b, a};  // select bit rides in the address
    @(negedge link_clk_in);
    cmd_out <= '{sdrb_pkg::OP_NOP, ~b, ~a};  // released lines never hold the old value
    repeat (gap - 2) @(negedge link_clk_in);
  endtask

  // beats launched half a cycle before each sampling edge: setup and skew met
  task automatic write(input logic b, input logic [12:0] a, input int lat_wr, input logic [63:0] d,
                       input logic [7:0] m);
    issue(sdrb_pkg::OP_WR, b, a, lat_wr);
    for (int j = 0; j < 4; j++) begin
      @(negedge link_clk_in);
      wdata_out <= '{d[16*j +: 8], d[16*j+8 +: 8], m[2*j], m[2*j+1]};
    end
    @(negedge link_clk_in);
    wdata_out <= ~wdata_out;
  endtask
endmodule

// *** tb/sdrb_core_tb.sv ***
module sdrb_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  sys_clk_in = 1'b0;
  logic                  link_clk   = 1'b0;
  logic                  reset_in   = 1'b1;
  sdrb_pkg::sdrb_cfg_s   cfg        = '0;
  sdrb_pkg::sdrb_cmd_s   cmd;
  sdrb_pkg::sdrb_wdata_s wdata;
  sdrb_pkg::sdrb_rdata_s rdata;
  logic                  term;
  logic [2:0]            fault;
  logic [1:0]            bank_open;
  int                    err_total = 0, comparisons = 0, cycles = 0, term_cnt = 0, lat_rd = 5, lat_wr = 5;
  logic [7:0]            mem [16];
  logic [15:0]           exp_q [$], obs_q [$];

  // ----------------------------------------------------------------
  // clocks, device, far side
  // ----------------------------------------------------------------
  always #25 sys_clk_in = ~sys_clk_in;
  // link clock offset so its edges never line up with the sys clock
  initial begin
    #3;
    forever #7.5 link_clk = ~link_clk;
  end
  sdrb_core i_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .link_clk_in(link_clk), .cfg_in(cfg),
    .cmd_in(cmd), .wdata_in(wdata), .rdata_out(rdata), .term_strobe_out(term), .fault_out(fault),
    .bank_open_out(bank_open));
  sdrb_ctrl_model i_ctrl (.link_clk_in(link_clk), .cmd_out(cmd), .wdata_out(wdata));

  // sample mid-cycle where link outputs are settled
  always @(negedge link_clk) begin
    if (rdata.valid === 1'b1) obs_q.push_back({rdata.rise, rdata.fall});
    if (term === 1'b1) term_cnt++;
  end
  // hang guard, well above the expected run
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  function automatic logic [2:0] bcol(input logic [2:0] col, input logic c, input int k);
    return c ? {col[2], col[1:0] + 2'(k)} : col + 3'(k);
  endfunction
  function automatic logic is_chop(input logic sel);
    return cfg.burst_field == sdrb_pkg::BF_FIXED_CHOP || (cfg.burst_field == sdrb_pkg::BF_ON_FLY && !sel);
  endfunction

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic do_reset;
    @(negedge sys_clk_in);
    reset_in <= 1'b1;
    repeat (8) @(negedge sys_clk_in);
    reset_in <= 1'b0;
    repeat (10) @(negedge sys_clk_in);
    check({rdata, term, fault, bank_open}, '0);
  endtask
  // waits for the history to drain first: latency must not change under a burst
  task automatic set_cfg(input logic [1:0] bf, input logic [1:0] am, input logic te);
    int a;
    repeat (45) @(negedge link_clk);
    a = (am == sdrb_pkg::ADD_CAS_M1) ? 4 : (am == sdrb_pkg::ADD_CAS_M2) ? 3 : 0;
    @(negedge sys_clk_in);
    cfg <= '{bf, 4'h5, 4'h5, am, te};
    lat_rd = 5 + a;
    lat_wr = 5 + a;
    repeat (10) @(negedge link_clk);
    obs_q.delete();
  endtask
  task automatic rd_issue(input logic b, input logic [2:0] col, input logic sel, input int gap);
    logic c;
    c = is_chop(sel);
    for (int k = 0; k < (c ? 4 : 8); k += 2)
      exp_q.push_back({mem[{b, bcol(col, c, k)}], mem[{b, bcol(col, c, k + 1)}]});
    i_ctrl.issue(sdrb_pkg::OP_RD, b, {sel, 9'h155, col}, gap);  // bits 11 to 3 are junk
  endtask
  task automatic rd_wait;
    repeat (lat_rd + 10) @(negedge link_clk);
    check(obs_q.size(), exp_q.size());
    while (exp_q.size() > 0 && obs_q.size() > 0) check(obs_q.pop_front(), exp_q.pop_front());
    obs_q.delete();
    exp_q.delete();
  endtask
  task automatic wr(input logic b, input logic [2:0] col, input logic sel, input logic [63:0] d,
                    input logic [7:0] m);
    logic c;
    c = is_chop(sel);
    for (int k = 0; k < (c ? 4 : 8); k++)
      if (!m[k] || cfg.term_en) mem[{b, bcol(col, c, k)}] = d[8*k +: 8];
    i_ctrl.write(b, {sel, 9'h0aa, col}, lat_wr, d, m);
    repeat (4) @(negedge link_clk);  // write-to-read and recovery room
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_bursts;
    set_cfg(sdrb_pkg::BF_ON_FLY, sdrb_pkg::ADD_ZERO, 1'b0);
    i_ctrl.issue(sdrb_pkg::OP_ACT, 1'b0, 13'h0000, 16);
    wr(1'b0, 3'h2, 1'b1, 64'h8877665544332211, 8'h00);
    wr(1'b0, 3'h6, 1'b0, 64'hf0e0d0c0b0a09080, 8'h06);
    rd_issue(1'b0, 3'h0, 1'b1, 4);
    rd_issue(1'b0, 3'h5, 1'b0, 4);
    rd_issue(1'b0, 3'h3, 1'b1, 4);
    rd_wait();
  endtask
  // fixed modes override the select bit; additive latency both ways
  task automatic t_modes;
    for (int i = 0; i < 2; i++) begin
      set_cfg(i ? sdrb_pkg::BF_FIXED_CHOP : sdrb_pkg::BF_FIXED_EIGHT,
              i ? sdrb_pkg::ADD_CAS_M2 : sdrb_pkg::ADD_CAS_M1, 1'b0);
      wr(1'b0, 3'h1, 1'(i), 64'h0123456789abcdef + 64'(i), 8'h00);
      rd_issue(1'b0, 3'h1, 1'(i), 4);
      rd_issue(1'b0, 3'h4, !1'(i), 4);
      rd_wait();
    end
  endtask
  task automatic t_term;
    set_cfg(sdrb_pkg::BF_ON_FLY, sdrb_pkg::ADD_ZERO, 1'b1);
    term_cnt = 0;
    wr(1'b0, 3'h0, 1'b1, 64'h1122334455667788, 8'hff);
    check(term_cnt, 4);
    rd_issue(1'b0, 3'h0, 1'b1, 4);
    rd_wait();
  endtask
  task automatic t_spacing;
    set_cfg(sdrb_pkg::BF_ON_FLY, sdrb_pkg::ADD_ZERO, 1'b0);
    i_ctrl.issue(sdrb_pkg::OP_ACT, 1'b1, 13'h0000, 11);
    i_ctrl.issue(sdrb_pkg::OP_RD, 1'b1, 13'h1000, 4);
    i_ctrl.issue(sdrb_pkg::OP_PRE, 1'b1, 13'h0000, 5);
    i_ctrl.issue(sdrb_pkg::OP_ACT, 1'b1, 13'h0000, 2);
    repeat (10) @(negedge sys_clk_in);
    check(fault, 3'h0);
    check(bank_open, 2'h3);
    i_ctrl.issue(sdrb_pkg::OP_RD, 1'b1, 13'h1000, 2);
    i_ctrl.issue(sdrb_pkg::OP_PRE, 1'b1, 13'h0000, 5);  // keep precharge_period so only trips
    repeat (10) @(negedge sys_clk_in);
    check(fault, 3'h1);
    i_ctrl.issue(sdrb_pkg::OP_ACT, 1'b1, 13'h0000, 2);
    i_ctrl.issue(sdrb_pkg::OP_PRE, 1'b1, 13'h0000, 30);
    check(fault, 3'h3);
    i_ctrl.issue(sdrb_pkg::OP_ACT, 1'b1, 13'h0000, 2);
    i_ctrl.issue(sdrb_pkg::OP_ACT, 1'b1, 13'h0000, 2);
    repeat (10) @(negedge sys_clk_in);
    check(fault, 3'h7);
    do_reset();
  endtask

  initial begin
    do_reset();
    t_bursts();
    t_modes();
    t_term();
    t_spacing();
    report_and_stop();
  end
endmodule
